// *** hdl/smf_decoder.sv ***
// Purpose: decode the servo motion control field into move and latch controls
// Assumes: software writes each new frame's field into the field register
// Notes: latch edges are seen between successive field writes
`timescale 1ns/1ps

module smf_decoder #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // motion and latch controls
  output smf_pkg::smf_ctrl_t     moveCtrl,
  output smf_pkg::smf_latch_t    latchA,
  output smf_pkg::smf_latch_t    latchB,
  output logic [11:0]            monitorEcho,
  output logic                   latchConflict
);

  // bus state
  logic              awHeld, next_awHeld;
  logic              wHeld, next_wHeld;
  logic [ADDR_W-1:0] awAddr, next_awAddr;
  logic [31:0]       wData, next_wData;
  logic [3:0]        wStrb, next_wStrb;
  logic              bValid, next_bValid;
  logic [1:0]        bResp, next_bResp;
  logic              rValid, next_rValid;
  logic [1:0]        rResp, next_rResp;
  logic [31:0]       rData, next_rData;
  // field state
  logic [31:0]       field, next_field;
  logic [31:0]       prevField, next_prevField;
  logic              fieldNew, next_fieldNew;
  logic              latchClear, next_latchClear;
  smf_pkg::smf_ctrl_t  ctrl, next_ctrl;
  smf_pkg::smf_latch_t la, next_la;
  smf_pkg::smf_latch_t lb, next_lb;
  logic [11:0]       mon, next_mon;
  logic              conflict, next_conflict;
  // helpers
  logic              doWrite;
  logic [31:0]       mergedData;
  logic              edgeA;
  logic              edgeB;
  logic [1:0]        srcA;
  logic [1:0]        srcB;

  // bus channel handshakes and register access
  always_comb begin
    next_awHeld    = awHeld;
    next_wHeld     = wHeld;
    next_awAddr    = awAddr;
    next_wData     = wData;
    next_wStrb     = wStrb;
    next_bValid    = bValid;
    next_bResp     = bResp;
    next_rValid    = rValid;
    next_rResp     = rResp;
    next_rData     = rData;
    next_field     = field;
    next_fieldNew  = 1'b0;
    next_latchClear = 1'b0;
    doWrite        = awHeld && wHeld && !bValid;
    mergedData     = field;
    for (int i = 0; i < 4; i++) begin
      if (wStrb[i]) begin
        mergedData[i*8 +: 8] = wData[i*8 +: 8];
      end
    end
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bValid = 1'b1;
      next_bResp  = smf_pkg::RESP_OKAY;
      case (awAddr[7:0])
        smf_pkg::ADDR_FIELD: begin
          next_field    = mergedData;
          next_fieldNew = 1'b1;
        end
        smf_pkg::ADDR_CTRL: begin
          next_latchClear = wStrb[0] && wData[0];
        end
        default: begin
          next_bResp = smf_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (s_axi_arvalid && !rValid) begin
      next_rValid = 1'b1;
      next_rResp  = smf_pkg::RESP_OKAY;
      case (s_axi_araddr[7:0])
        smf_pkg::ADDR_FIELD:   next_rData = field;
        smf_pkg::ADDR_CTRL:    next_rData = 32'h00000000;
        smf_pkg::ADDR_STATUS:  next_rData = {25'h0, conflict, ctrl.filterBad, ctrl.stopStyleBad,
                                             ctrl.referenceFilterSelect, ctrl.stopImmediate,
                                             ctrl.abortMove | ctrl.holdMove};
        smf_pkg::ADDR_LATCH:   next_rData = {26'h0, lb.armed, lb.source, la.armed, la.source};
        smf_pkg::ADDR_MONITOR: next_rData = {20'h0, mon};
        default: begin
          next_rData = 32'h00000000;
          next_rResp = smf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  // field decode and latch arming
  always_comb begin
    edgeA          = fieldNew && field[smf_pkg::REQA_BIT] && !prevField[smf_pkg::REQA_BIT];
    edgeB          = fieldNew && field[smf_pkg::REQB_BIT] && !prevField[smf_pkg::REQB_BIT];
    srcA           = field[smf_pkg::SRCA_LSB +: 2];
    srcB           = field[smf_pkg::SRCB_LSB +: 2];
    next_prevField = fieldNew ? field : prevField;
    next_la        = la;
    next_lb        = lb;
    next_conflict  = conflict;
    // decode has no alarm input: it acts whatever the command state is
    next_ctrl.holdMove              = field[smf_pkg::PAUSE_BIT];
    next_ctrl.abortMove             = field[smf_pkg::CANCEL_BIT];
    next_ctrl.stopImmediate         = field[smf_pkg::STOP_LSB +: 2] == smf_pkg::STOP_IMMED;
    next_ctrl.stopStyleBad          = field[smf_pkg::STOP_LSB + 1];
    next_ctrl.referenceFilterSelect = field[smf_pkg::FILT_LSB +: 2];
    next_ctrl.filterBad             = field[smf_pkg::FILT_LSB +: 2] == 2'h3;
    next_mon = {field[smf_pkg::MONC_LSB +: 4], field[smf_pkg::MONB_LSB +: 4],
                field[smf_pkg::MONA_LSB +: 4]}; // reserved bits never decoded
    if (latchClear) begin
      next_la.armed = 1'b0;
      next_lb.armed = 1'b0;
      next_conflict = 1'b0;
    end
    // a request whose source the other armed channel already uses is dropped
    if (edgeA && edgeB && srcA == srcB) begin
      // a wins the tie, unless b already holds that source
      if (!(lb.armed && lb.source == srcA)) begin
        next_la = '{armed: 1'b1, source: srcA};
      end
      next_conflict = 1'b1;
    end else begin
      if (edgeA) begin
        if (lb.armed && lb.source == srcA) begin
          next_conflict = 1'b1;
        end else begin
          next_la = '{armed: 1'b1, source: srcA};
        end
      end
      if (edgeB) begin
        if (la.armed && la.source == srcB) begin
          next_conflict = 1'b1;
        end else begin
          next_lb = '{armed: 1'b1, source: srcB};
        end
      end
    end
  end

  // register all state
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddr     <= '0;
      wData      <= 32'h00000000;
      wStrb      <= 4'h0;
      bValid     <= 1'b0;
      bResp      <= smf_pkg::RESP_OKAY;
      rValid     <= 1'b0;
      rResp      <= smf_pkg::RESP_OKAY;
      rData      <= 32'h00000000;
      field      <= smf_pkg::FIELD_RESET;
      prevField  <= smf_pkg::FIELD_RESET;
      fieldNew   <= 1'b0;
      latchClear <= 1'b0;
      ctrl       <= '0;
      la         <= '0;
      lb         <= '0;
      mon        <= 12'h000;
      conflict   <= 1'b0;
    end else begin
      awHeld     <= next_awHeld;
      wHeld      <= next_wHeld;
      awAddr     <= next_awAddr;
      wData      <= next_wData;
      wStrb      <= next_wStrb;
      bValid     <= next_bValid;
      bResp      <= next_bResp;
      rValid     <= next_rValid;
      rResp      <= next_rResp;
      rData      <= next_rData;
      field      <= next_field;
      prevField  <= next_prevField;
      fieldNew   <= next_fieldNew;
      latchClear <= next_latchClear;
      ctrl       <= next_ctrl;
      la         <= next_la;
      lb         <= next_lb;
      mon        <= next_mon;
      conflict   <= next_conflict;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_bvalid  = bValid;
  assign s_axi_bresp   = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid  = rValid;
  assign s_axi_rresp   = rResp;
  assign s_axi_rdata   = rData;
  assign moveCtrl      = ctrl;
  assign latchA        = la;
  assign latchB        = lb;
  assign monitorEcho   = mon;
  assign latchConflict = conflict;

endmodule

// *** hdl/smf_pkg.sv ***
// Purpose: constants and carriers for the servo motion control field decoder
// Assumes: field is the 32-bit word from bytes 4..7 of a servo command frame
// Notes: byte addresses of the register map are word aligned
package smf_pkg;
  // field bit positions
  localparam int PAUSE_BIT    = 0;
  localparam int CANCEL_BIT   = 1;
  localparam int STOP_LSB     = 2;
  localparam int FILT_LSB     = 4;
  localparam int REQA_BIT     = 8;
  localparam int REQB_BIT     = 9;
  localparam int SRCA_LSB     = 10;
  localparam int SRCB_LSB     = 12;
  localparam int MONA_LSB     = 16;
  localparam int MONB_LSB     = 20;
  localparam int MONC_LSB     = 24;
  localparam logic [31:0] FIELD_USED_MASK = 32'h0fff3f3f;
  // frame placement of the field
  localparam int FIELD_FIRST_BYTE = 4;
  localparam int FIELD_LAST_BYTE  = 7;
  // register byte addresses
  localparam logic [7:0] ADDR_FIELD   = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_LATCH   = 8'h0c;
  localparam logic [7:0] ADDR_MONITOR = 8'h10;
  // reset values
  localparam logic [31:0] FIELD_RESET = 32'h00000000;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // stop styles
  localparam logic [1:0] STOP_DECEL = 2'h0;
  localparam logic [1:0] STOP_IMMED = 2'h1;
  // reference filters
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_EXP  = 2'h1;
  localparam logic [1:0] FILT_AVG  = 2'h2;

  // decoded level controls
  typedef struct packed {
    logic       holdMove;
    logic       abortMove;
    logic       stopImmediate;
    logic [1:0] referenceFilterSelect;
    logic       stopStyleBad;
    logic       filterBad;
  } smf_ctrl_t;

  // one latch channel
  typedef struct packed {
    logic       armed;
    logic [1:0] source;
  } smf_latch_t;
endpackage

// *** test/smf_decoder_asserts.sv ***
// Purpose: port checks for the motion control field decoder
// Assumes: bound to smf_decoder, one clock, sync reset
// Notes: control outputs move only after a write answer
`timescale 1ns/1ps
module smf_decoder_asserts (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // bus requests and answers
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  // decoded outputs
  input wire smf_pkg::smf_ctrl_t  moveCtrl,
  input wire smf_pkg::smf_latch_t latchA,
  input wire smf_pkg::smf_latch_t latchB,
  input wire logic [11:0]         monitorEcho
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // answer steps of the bus
  sequence rTake; s_axi_rvalid && s_axi_rready; endsequence
  sequence bTake; s_axi_bvalid && s_axi_bready; endsequence
  sequence wrAnswered; $past(s_axi_bvalid); endsequence
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  r_done_a: assert property (rTake |=> !s_axi_rvalid)
    else $error("read answer not released");
  b_done_a: assert property (bTake |=> !s_axi_bvalid)
    else $error("write answer not released");
  ctrl_follow_a: assert property ($changed(moveCtrl) |-> wrAnswered)
    else $error("move controls changed without a write");
  mon_follow_a: assert property ($changed(monitorEcho) |-> wrAnswered)
    else $error("monitor echo changed without a write");
  latch_edge_a: assert property ($rose(latchA.armed) || $rose(latchB.armed) |-> wrAnswered)
    else $error("latch armed without a write");
  aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready not lowered after address taken");
  w_hold_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("wready not lowered after data taken");
  // a source may only move when a new request edge arrives with a write
  srca_hold_a: assert property (latchA.armed && $past(latchA.armed) && !$past(s_axi_bvalid)
                                |-> $stable(latchA.source))
    else $error("source a moved while armed");
  srcb_hold_a: assert property (latchB.armed && $past(latchB.armed) && !$past(s_axi_bvalid)
                                |-> $stable(latchB.source))
    else $error("source b moved while armed");
  no_dup_a: assert property (latchA.armed && latchB.armed |-> latchA.source != latchB.source)
    else $error("both latches armed on one source");
  filt_bad_a: assert property (moveCtrl.filterBad == (moveCtrl.referenceFilterSelect == 2'h3))
    else $error("filter flag wrong");
endmodule

// *** test/smf_host.sv ***
// Purpose: host master model sending the field over axi4-lite
// Assumes: bready and rready are held high by the bench
// Notes: waits have no timeout; a hung wait ends only by the bench watchdog
`timescale 1ns/1ps
module smf_host (
  // clock
  input wire logic    clk,
  // write side
  output logic [7:0]  awaddr,
  output logic        awvalid,
  input wire logic    awready,
  output logic [31:0] wdata,
  output logic        wvalid,
  input wire logic    wready,
  input wire logic    bvalid,
  // read side
  output logic [7:0]  araddr,
  output logic        arvalid,
  input wire logic    arready,
  input wire logic    rvalid
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
  end
  // one write of a data word under the bench byte strobes, released lines inverted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge clk); while (!bvalid);
  endtask
  // one read, data taken by the bench monitor
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clk); while (!rvalid);
  endtask
endmodule

// *** test/test_smf_decoder.sv ***
// Purpose: self-checking bench for the field decoder
// Assumes: host model drives the bus, monitor checks reads
// Notes: latch cases come from a table
`timescale 1ns/1ps
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin nErrors++; $display("Error %s exp %0h seen %0h", n, e, s); end end
module test_smf_decoder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, f;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, latchConflict;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  smf_pkg::smf_ctrl_t moveCtrl;
  smf_pkg::smf_latch_t latchA, latchB;
  logic [11:0] monitorEcho;
  logic [33:0] expQ[$];
  logic [33:0] x;
  logic [6:0] e;
  logic [1:0] respQ[$];
  logic [1:0] r;
  int nErrors = 0;
  int checkCount = 0;
  localparam logic [31:0] LF [16] = '{32'h0, 32'h900, 32'hd00, 32'h2f00, 32'h1, 32'h0, 32'h1200, 32'h1300,
                                      32'h0, 32'h1, 32'h3f00, 32'h0, 32'h2200, 32'h3200, 32'h0, 32'h500};
  localparam logic [6:0] LE [16] = '{7'h00, 7'h60, 7'h60, 7'h61, 7'h00, 7'h00, 7'h0a, 7'h4a,
                                     7'h4a, 7'h00, 7'h71, 7'h71, 7'h7d, 7'h7d, 7'h7d, 7'h5d};
  always #2.5 clk = ~clk;
  smf_decoder smf_decoder_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .moveCtrl, .latchA, .latchB,
    .monitorEcho, .latchConflict);
  smf_host smf_host_i (.clk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bvalid(s_axi_bvalid),
    .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rvalid(s_axi_rvalid));
  // each read answer takes the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      x = expQ.pop_front();
      `CHK("read", x, {s_axi_rresp, s_axi_rdata})
    end
  end
  // each write answer takes the oldest response note
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      r = respQ.pop_front();
      `CHK("bresp", r, s_axi_bresp)
    end
  end
  // note the expected write response, then write
  task automatic wrx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] v);
    respQ.push_back(v);
    smf_host_i.wr(a, d);
  endtask
  // note the expected answer, then read
  task automatic rdx(input logic [7:0] a, input logic [33:0] v);
    expQ.push_back(v);
    smf_host_i.rd(a);
  endtask
  // verdict and end of run
  task complete_run;
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog on a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    nErrors++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(32'he90b737b));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("latch", 7'h00, {latchA, latchB, latchConflict})
    rdx(smf_pkg::ADDR_FIELD, {smf_pkg::RESP_OKAY, smf_pkg::FIELD_RESET});
    // every stop style and filter code, random pause, cancel, monitors, reserved
    for (int i = 0; i < 16; i++) begin
      f = ($urandom() & 32'hffffc0c3) | (32'(i) << 2);
      e = {f[0], f[1], f[3:2] == 2'h1, f[5:4], f[3], f[5:4] == 2'h3};
      wrx(smf_pkg::ADDR_FIELD, f, smf_pkg::RESP_OKAY);
      @(posedge clk);
      `CHK("moveCtrl", e, moveCtrl)
      `CHK("monitorEcho", f[27:16], monitorEcho)
      rdx(smf_pkg::ADDR_STATUS, {2'b00, 26'h0, e[0], e[1], e[3:2], e[4], e[6] | e[5]});
      rdx(smf_pkg::ADDR_MONITOR, {2'b00, 20'h0, f[27:16]});
    end
    // latch edges, steady levels, duplicate and tied sources, re-arm and clear
    for (int i = 0; i < 16; i++) begin
      wrx((i == 4 || i == 9) ? smf_pkg::ADDR_CTRL : smf_pkg::ADDR_FIELD, LF[i], smf_pkg::RESP_OKAY);
      @(posedge clk);
      x = {27'h0, latchA.armed, latchA.armed ? latchA.source : 2'h0, latchB.armed,
           latchB.armed ? latchB.source : 2'h0, latchConflict};
      `CHK("latch", LE[i], x[6:0])
    end
    // unmapped places refuse and write nothing
    wrx(8'h14, 32'hffffffff, smf_pkg::RESP_SLVERR);
    rdx(8'h14, {smf_pkg::RESP_SLVERR, 32'h0});
    rdx(smf_pkg::ADDR_CTRL, {smf_pkg::RESP_OKAY, 32'h0});
    rdx(smf_pkg::ADDR_FIELD, {smf_pkg::RESP_OKAY, 32'h500});
    // a single byte strobe changes only the monitor codes a and b
    s_axi_wstrb <= 4'h4;
    wrx(smf_pkg::ADDR_FIELD, 32'hffffffff, smf_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    @(posedge clk);
    `CHK("monitorEcho", 12'h0ff, monitorEcho)
    rdx(smf_pkg::ADDR_FIELD, {smf_pkg::RESP_OKAY, 32'h00ff0500});
    repeat (4) @(posedge clk);
    `CHK("notes left", 0, expQ.size() + respQ.size())
    complete_run();
  end
endmodule
bind smf_decoder smf_decoder_asserts smf_decoder_asserts_i (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .moveCtrl, .latchA, .latchB, .monitorEcho);
